//--- port_a_pkg.sv
// Constants for the eight-bit port with alternate pin steering.
// Assumes one 50 MHz core clock and an 8-bit register port.
`default_nettype none

package port_a_pkg;

   ////////////////////////////////////////////////////////////////////
   // Bus shape
   localparam int unsigned ADDR_W     = 3;
   localparam int unsigned DATA_W     = 8;

   // Register offsets
   localparam logic [2:0]  OFF_PORT   = 3'h0;
   localparam logic [2:0]  OFF_DIR    = 3'h1;
   localparam logic [2:0]  OFF_LATCH  = 3'h2;
   localparam logic [2:0]  OFF_ANALOG = 3'h3;
   localparam logic [2:0]  OFF_STEER  = 3'h4;
   localparam logic [2:0]  OFF_BSET   = 3'h5;
   localparam logic [2:0]  OFF_BCLR   = 3'h6;

   ////////////////////////////////////////////////////////////////////
   // Reset values and implemented-bit masks
   localparam logic [7:0]  DIR_RST    = 8'hFF;
   localparam logic [7:0]  LATCH_RST  = 8'h00;
   localparam logic [7:0]  ANALOG_RST = 8'h2F;
   localparam logic [7:0]  ANALOG_MSK = 8'h2F;
   localparam logic [7:0]  STEER_RST  = 8'h00;
   localparam logic [7:0]  STEER_MSK  = 8'h03;

   // Field positions
   localparam int unsigned TMR_SEL_BIT = 1;
   localparam int unsigned CCP_SEL_BIT = 0;
   localparam int unsigned PRIO_PIN    = 6;

   // Synchroniser vector: port pins, then the four steered pins
   localparam int unsigned EXT_W      = 12;
   localparam int unsigned EXT_B4     = 8;
   localparam int unsigned EXT_B5     = 9;
   localparam int unsigned EXT_C1     = 10;
   localparam int unsigned EXT_E7     = 11;

endpackage : port_a_pkg

`default_nettype wire

//--- port_a_with_pin_steering.sv
// Eight-bit bidirectional port with pin-6 output priority and a
// steering register for the timer-3 clock and capture-2 pins.
// Assumes a register master on clk; pins come from the board.
//
// The implementer's own choices: the register offsets and strobed register access.
`default_nettype none

// What this block does
// - Steering bit 1 picks timer-3 clock from B4 when one, B5 when zero
// - Steering bit 0 puts capture-2 on E7 when one, C1 when zero
// - Steering leaves direction alone; overrides follow selected pin
// - Upper six steering bits read zero and ignore writes
// - Eight pins, each with direction, latch and level bits
// - Direction one turns the pin driver off
// - Direction zero drives the pin from its latch bit
// - Port read gives pin levels; port write goes to the latch
// - Bit set and clear writes are read-modify-write from current pin levels
// - Direction still controls the driver in analog mode
// - Analog-select one makes digital reads of the pin zero
// - Analog select never changes digital outputs
// - Implemented analog-select bits come up set after reset
// - Highest priority enabled output function owns the pin
// - Pin 6: clock output, then oscillator output, then latch
// - Analog inputs live in analog mode; outputs still may drive
// - Latch read returns the latch, not the pins
module port_a_with_pin_steering (
   input  wire logic       clk,
   input  wire logic       arst_n,
   input  wire logic [2:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr_stb,
   input  wire logic       rd_stb,
   output logic      [7:0] rdata,
   input  wire logic [7:0] pin_in,
   output logic      [7:0] pin_out,
   output logic      [7:0] pin_oe,
   output logic      [7:0] analog_enable,
   input  wire logic       clock_output_en,
   input  wire logic       clock_output_val,
   input  wire logic       osc_out_en,
   input  wire logic       osc_out_val,
   input  wire logic       portb_bit4_in,
   input  wire logic       portb_bit5_in,
   output logic            timer_three_clock_input,
   input  wire logic       portc_bit1_in,
   input  wire logic       porte_bit7_in,
   input  wire logic       capture_out_en,
   input  wire logic       capture_out_val,
   output logic            capture_compare_two_function,
   output logic            portc_bit1_ovr_en,
   output logic            portc_bit1_ovr_val,
   output logic            porte_bit7_ovr_en,
   output logic            porte_bit7_ovr_val
);

   ////////////////////////////////////////////////////////////////////
   // Declarations
   localparam int unsigned EW = port_a_pkg::EXT_W;

   logic [EW-1:0] sync1_reg;
   logic [EW-1:0] sync2_reg;
   logic [EW-1:0] sync3_reg;
   logic [EW-1:0] level_reg;
   logic [7:0]    dir_reg;
   logic [7:0]    latch_reg;
   logic [7:0]    analog_reg;
   logic [7:0]    steer_reg;
   logic [7:0]    port_read;
   logic [7:0]    rdata_next;
   logic [7:0]    out_next;
   logic [7:0]    oe_next;
   logic          wr_port;
   logic          wr_dir;
   logic          wr_latch;
   logic          wr_analog;
   logic          wr_steer;
   logic          wr_bset;
   logic          wr_bclr;

   ////////////////////////////////////////////////////////////////////
   // Write decode
   assign wr_port   = wr_stb && (addr == port_a_pkg::OFF_PORT);
   assign wr_dir    = wr_stb && (addr == port_a_pkg::OFF_DIR);
   assign wr_latch  = wr_stb && (addr == port_a_pkg::OFF_LATCH);
   assign wr_analog = wr_stb && (addr == port_a_pkg::OFF_ANALOG);
   assign wr_steer  = wr_stb && (addr == port_a_pkg::OFF_STEER);
   assign wr_bset   = wr_stb && (addr == port_a_pkg::OFF_BSET);
   assign wr_bclr   = wr_stb && (addr == port_a_pkg::OFF_BCLR);

   ////////////////////////////////////////////////////////////////////
   // Three-stage pin synchroniser
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
         sync3_reg <= '0;
      end else begin
         sync1_reg <= {porte_bit7_in, portc_bit1_in,
                       portb_bit5_in, portb_bit4_in, pin_in};
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
      end
   end

   // Accept a level once stages two and three agree
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         level_reg <= '0;
      end else begin
         for (int i = 0; i < EW; i++) begin
            if (sync2_reg[i] == sync3_reg[i]) begin
               level_reg[i] <= sync3_reg[i];
            end
         end
      end
   end

   // Digital view of the pins; analog pins read zero
   assign port_read = level_reg[7:0] & ~analog_reg;

   ////////////////////////////////////////////////////////////////////
   // Direction register, one bit per pin
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         dir_reg <= port_a_pkg::DIR_RST;
      end else if (wr_dir) begin
         dir_reg <= wdata;
      end
   end

   // Output latch: direct, port and bit-wise read-modify-write paths
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         latch_reg <= port_a_pkg::LATCH_RST;
      end else if (wr_latch || wr_port) begin
         latch_reg <= wdata;
      end else if (wr_bset) begin
         latch_reg <= port_read | wdata;
      end else if (wr_bclr) begin
         latch_reg <= port_read & ~wdata;
      end
   end

   // Analog select, unimplemented bits held at zero
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         analog_reg <= port_a_pkg::ANALOG_RST;
      end else if (wr_analog) begin
         analog_reg <= wdata & port_a_pkg::ANALOG_MSK;
      end
   end

   // Steering register, two live bits
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         steer_reg <= port_a_pkg::STEER_RST;
      end else if (wr_steer) begin
         steer_reg <= wdata & port_a_pkg::STEER_MSK;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Read mux, answer in the following cycle
   always_comb begin
      rdata_next = 8'h00;
      case (addr)
         port_a_pkg::OFF_PORT:   rdata_next = port_read;
         port_a_pkg::OFF_DIR:    rdata_next = dir_reg;
         port_a_pkg::OFF_LATCH:  rdata_next = latch_reg;
         port_a_pkg::OFF_ANALOG: rdata_next = analog_reg;
         port_a_pkg::OFF_STEER:  rdata_next = steer_reg;
         default:                rdata_next = 8'h00;
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata <= 8'h00;
      end else if (rd_stb) begin
         rdata <= rdata_next;
      end else begin
         rdata <= 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Pin drive with pin-6 priority; analog select plays no part
   always_comb begin
      out_next = latch_reg;
      oe_next  = ~dir_reg;
      if (clock_output_en) begin
         out_next[port_a_pkg::PRIO_PIN] = clock_output_val;
         oe_next[port_a_pkg::PRIO_PIN]  = 1'b1;
      end else if (osc_out_en) begin
         out_next[port_a_pkg::PRIO_PIN] = osc_out_val;
         oe_next[port_a_pkg::PRIO_PIN]  = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pin_out       <= 8'h00;
         pin_oe        <= 8'h00;
         analog_enable <= 8'h00;
      end else begin
         pin_out       <= out_next;
         pin_oe        <= oe_next;
         analog_enable <= analog_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Steered peripheral routing
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         timer_three_clock_input      <= 1'b0;
         capture_compare_two_function <= 1'b0;
         portc_bit1_ovr_en            <= 1'b0;
         portc_bit1_ovr_val           <= 1'b0;
         porte_bit7_ovr_en            <= 1'b0;
         porte_bit7_ovr_val           <= 1'b0;
      end else begin
         timer_three_clock_input <=
            steer_reg[port_a_pkg::TMR_SEL_BIT] ?
            level_reg[port_a_pkg::EXT_B4] :
            level_reg[port_a_pkg::EXT_B5];
         capture_compare_two_function <=
            steer_reg[port_a_pkg::CCP_SEL_BIT] ?
            level_reg[port_a_pkg::EXT_E7] :
            level_reg[port_a_pkg::EXT_C1];
         porte_bit7_ovr_en  <= capture_out_en &&
            steer_reg[port_a_pkg::CCP_SEL_BIT];
         porte_bit7_ovr_val <= capture_out_val;
         portc_bit1_ovr_en  <= capture_out_en &&
            !steer_reg[port_a_pkg::CCP_SEL_BIT];
         portc_bit1_ovr_val <= capture_out_val;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Checks
   property p_steer_upper_zero;
      @(posedge clk) disable iff (!arst_n)
      (rd_stb && addr == port_a_pkg::OFF_STEER) |=> (rdata[7:2] == 6'h00);
   endproperty
   a_steer_upper_zero: assert property (p_steer_upper_zero)
      else $error("steering upper bits not zero");

   property p_timer_sel;
      @(posedge clk) disable iff (!arst_n)
      (steer_reg[1] && $stable(steer_reg)) |=>
      (timer_three_clock_input == $past(level_reg[8]));
   endproperty
   a_timer_sel: assert property (p_timer_sel)
      else $error("timer clock not taken from B4");

   property p_capture_route;
      @(posedge clk) disable iff (!arst_n)
      (capture_out_en && !steer_reg[0]) |=>
      (portc_bit1_ovr_en && !porte_bit7_ovr_en);
   endproperty
   a_capture_route: assert property (p_capture_route)
      else $error("capture override on wrong pin");

   property p_steer_keeps_dir;
      @(posedge clk) disable iff (!arst_n)
      (wr_steer && !wr_dir) |=> (dir_reg == $past(dir_reg));
   endproperty
   a_steer_keeps_dir: assert property (p_steer_keeps_dir)
      else $error("steering write changed direction");

   property p_input_off;
      @(posedge clk) disable iff (!arst_n)
      1'b1 |=> ((pin_oe[5:0] & $past(dir_reg[5:0])) == 6'h00);
   endproperty
   a_input_off: assert property (p_input_off)
      else $error("driver on for input pin");

   property p_drive_latch;
      @(posedge clk) disable iff (!arst_n)
      (dir_reg[0] == 1'b0) |=>
      (pin_oe[0] && pin_out[0] == $past(latch_reg[0]));
   endproperty
   a_drive_latch: assert property (p_drive_latch)
      else $error("output pin not driven from latch");

   property p_port_read;
      @(posedge clk) disable iff (!arst_n)
      (rd_stb && addr == port_a_pkg::OFF_PORT) |=>
      (rdata == ($past(level_reg[7:0]) & ~$past(analog_reg)));
   endproperty
   a_port_read: assert property (p_port_read)
      else $error("port read wrong");

   property p_rmw_set;
      @(posedge clk) disable iff (!arst_n)
      wr_bset |=> (latch_reg == ($past(port_read) | $past(wdata)));
   endproperty
   a_rmw_set: assert property (p_rmw_set)
      else $error("bit set did not use pin levels");

   property p_analog_out;
      @(posedge clk) disable iff (!arst_n)
      (!dir_reg[1] && analog_reg[1]) |=> pin_oe[1];
   endproperty
   a_analog_out: assert property (p_analog_out)
      else $error("analog select disabled driver");

   property p_pin6_prio;
      @(posedge clk) disable iff (!arst_n)
      clock_output_en |=>
      (pin_oe[6] && pin_out[6] == $past(clock_output_val));
   endproperty
   a_pin6_prio: assert property (p_pin6_prio)
      else $error("clock output lost pin 6");

   property p_latch_read;
      @(posedge clk) disable iff (!arst_n)
      (rd_stb && addr == port_a_pkg::OFF_LATCH) |=>
      (rdata == $past(latch_reg));
   endproperty
   a_latch_read: assert property (p_latch_read)
      else $error("latch read wrong");

   property p_dir_write;
      @(posedge clk) disable iff (!arst_n)
      wr_dir |=> (dir_reg == $past(wdata));
   endproperty
   a_dir_write: assert property (p_dir_write)
      else $error("direction write lost");

   property p_analog_unimpl;
      @(posedge clk) disable iff (!arst_n)
      wr_analog |=> ((analog_reg & ~port_a_pkg::ANALOG_MSK) == 8'h00);
   endproperty
   a_analog_unimpl: assert property (p_analog_unimpl)
      else $error("analog unimplemented bit set");

   c_osc_drive: cover property (@(posedge clk) disable iff (!arst_n)
      (osc_out_en && !clock_output_en) ##1 pin_oe[6]);
   c_steer_swap: cover property (@(posedge clk) disable iff (!arst_n)
      wr_steer ##1 $changed(steer_reg));
   c_rmw_clear: cover property (@(posedge clk) disable iff (!arst_n)
      wr_bclr ##1 $changed(latch_reg));

endmodule : port_a_with_pin_steering

`default_nettype wire

//--- port_a_board.sv
// Board model for the port pins and the four steered pins.
// Assumes undriven pins follow levels chosen by the bench.
`default_nettype none

module port_a_board (
   input  wire logic [7:0] pin_out,
   input  wire logic [7:0] pin_oe,
   input  wire logic [7:0] ext_level,
   input  wire logic [3:0] ext_steer,
   output logic      [7:0] pin_in,
   output logic      [3:0] steer_in
);
   timeunit 1ns;
   timeprecision 1ns;

   // Driven pins show the device value, others the board level
   assign pin_in   = (pin_out & pin_oe) | (ext_level & ~pin_oe);
   // Steered pins: b4, b5, c1, e7 from bit 0 up
   assign steer_in = ext_steer;
endmodule : port_a_board

`default_nettype wire

//--- port_a_with_pin_steering_tb_top.sv
// Self-checking bench for the port with pin steering.
// Assumes the board model and the design package are compiled first.
`default_nettype none

`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end

module port_a_with_pin_steering_tb_top;
   timeunit 1ns;
   timeprecision 1ns;

   typedef struct {logic [2:0] a; logic [7:0] w; logic [7:0] e;} row_t;

   logic       clk, arst_n, wr_stb, rd_stb;
   logic [2:0] addr;
   logic [7:0] wdata, rdata, pin_in, pin_out, pin_oe, an_en, ext_level, d;
   logic [3:0] ext_steer, steer_in;
   logic       clk_out_en, clk_out_val, osc_out_en, osc_out_val;
   logic       tmr_clk, cap_in, cap_en, cap_val;
   logic       c1_en, c1_val, e7_en, e7_val;
   int         n_errors, n_tests, cyc;
   row_t       rows [7];

   ////////////////////////////////////////////////////////////////////
   // Design and board
   port_a_with_pin_steering u_dut (
      .clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata),
      .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
      .analog_enable(an_en), .clock_output_en(clk_out_en),
      .clock_output_val(clk_out_val), .osc_out_en(osc_out_en),
      .osc_out_val(osc_out_val), .portb_bit4_in(steer_in[0]),
      .portb_bit5_in(steer_in[1]), .timer_three_clock_input(tmr_clk),
      .portc_bit1_in(steer_in[2]), .porte_bit7_in(steer_in[3]),
      .capture_out_en(cap_en), .capture_out_val(cap_val),
      .capture_compare_two_function(cap_in),
      .portc_bit1_ovr_en(c1_en), .portc_bit1_ovr_val(c1_val),
      .porte_bit7_ovr_en(e7_en), .porte_bit7_ovr_val(e7_val));

   port_a_board u_board (
      .pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level),
      .ext_steer(ext_steer), .pin_in(pin_in), .steer_in(steer_in));

   ////////////////////////////////////////////////////////////////////
   // Clock and hang guard
   always #10 clk = ~clk;

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_errors++;
         print_verdict();
      end
   end

   // Bus cycles
   task automatic wr(input logic [2:0] a, input logic [7:0] w);
      @(posedge clk);
      addr   <= a;
      wdata  <= w;
      wr_stb <= 1'b1;
      @(posedge clk);
      wr_stb <= 1'b0;
   endtask : wr

   task automatic rd(input logic [2:0] a, output logic [7:0] v);
      @(posedge clk);
      addr   <= a;
      rd_stb <= 1'b1;
      @(posedge clk);
      rd_stb <= 1'b0;
      #1;
      v = rdata;
   endtask : rd

   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : settle

   task automatic print_verdict;
      if (n_errors == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : print_verdict

   ////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      clk = 0; arst_n = 0; addr = 0; wdata = 0; wr_stb = 0; rd_stb = 0;
      clk_out_en = 0; clk_out_val = 0; osc_out_en = 0; osc_out_val = 0;
      cap_en = 0; cap_val = 0; ext_level = 8'h00; ext_steer = 4'h0;
      n_errors = 0; n_tests = 0; cyc = 0;
      rows = '{'{3'h1, 8'h5A, 8'h5A}, '{3'h2, 8'hC3, 8'hC3},
               '{3'h3, 8'hFF, 8'h2F}, '{3'h3, 8'hD0, 8'h00},
               '{3'h4, 8'hFF, 8'h03}, '{3'h4, 8'hFC, 8'h00},
               '{3'h7, 8'hFF, 8'h00}};
      settle(3);
      `CHK({pin_oe, rdata, an_en}, 24'h000000);
      @(posedge clk) arst_n <= 1'b1;
      // Reset values of all registers
      rd(port_a_pkg::OFF_DIR, d);    `CHK(d, 8'hFF);
      rd(port_a_pkg::OFF_LATCH, d);  `CHK(d, 8'h00);
      rd(port_a_pkg::OFF_ANALOG, d); `CHK(d, 8'h2F);
      rd(port_a_pkg::OFF_STEER, d);  `CHK(d, 8'h00);
      `CHK(an_en, 8'h2F);
      // Plain register rows
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].w);
         rd(rows[i].a, d);
         `CHK(d, rows[i].e);
      end
      // Drive with analog still selected
      wr(port_a_pkg::OFF_ANALOG, 8'h2F);
      wr(port_a_pkg::OFF_DIR, 8'h0F);
      wr(port_a_pkg::OFF_LATCH, 8'hA5);
      ext_level <= 8'h3C;
      settle(8);
      `CHK(pin_oe, 8'hF0);
      `CHK(pin_out & pin_oe, 8'hA0);
      `CHK(an_en, 8'h2F);
      rd(port_a_pkg::OFF_PORT, d); `CHK(d, 8'h80);
      // Digital input use after clearing analog select
      wr(port_a_pkg::OFF_ANALOG, 8'h00);
      rd(port_a_pkg::OFF_PORT, d); `CHK(d, 8'hAC);
      // Bit set and clear start from pin levels
      wr(port_a_pkg::OFF_BSET, 8'h01);
      rd(port_a_pkg::OFF_LATCH, d); `CHK(d, 8'hAD);
      wr(port_a_pkg::OFF_BCLR, 8'h80);
      rd(port_a_pkg::OFF_LATCH, d); `CHK(d, 8'h2C);
      wr(port_a_pkg::OFF_PORT, 8'h96);
      rd(port_a_pkg::OFF_LATCH, d); `CHK(d, 8'h96);
      // Pin 6 output priority with all pins as inputs
      wr(port_a_pkg::OFF_DIR, 8'hFF);
      for (int k = 0; k < 4; k++) begin
         @(posedge clk);
         clk_out_en  <= k[1];
         osc_out_en  <= k[0];
         clk_out_val <= 1'b0;
         osc_out_val <= 1'b1;
         settle(2);
         `CHK({pin_oe[6], pin_out[6]}, {|k[1:0], k[0] & ~k[1]});
         `CHK(pin_oe & 8'hBF, 8'h00);
      end
      @(posedge clk) clk_out_en <= 1'b0;
      osc_out_en <= 1'b0;
      // Steering of timer clock and capture function
      ext_steer <= 4'b1001;
      cap_en    <= 1'b1;
      cap_val   <= 1'b1;
      for (int s = 0; s < 4; s++) begin
         wr(port_a_pkg::OFF_STEER, 8'(s));
         settle(8);
         `CHK(tmr_clk, s[1]);
         `CHK(cap_in, s[0]);
         `CHK({e7_en, c1_en}, {s[0], ~s[0]});
         `CHK(s[0] ? e7_val : c1_val, 1'b1);
         rd(port_a_pkg::OFF_DIR, d); `CHK(d, 8'hFF);
      end
      // Reset in mid-run
      @(posedge clk) arst_n <= 1'b0;
      settle(1);
      `CHK({pin_oe, tmr_clk, e7_en}, 10'h000);
      @(posedge clk) arst_n <= 1'b1;
      rd(port_a_pkg::OFF_ANALOG, d); `CHK(d, 8'h2F);
      rd(port_a_pkg::OFF_STEER, d);  `CHK(d, 8'h00);
      print_verdict();
   end
endmodule : port_a_with_pin_steering_tb_top

`default_nettype wire
